// ---- mrs_manual_ramp.sv ----
// Motor operated potentiometer speed reference with rate limits and clamps
`timescale 1ns/10ps
module mrs_manual_ramp
  import mrs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              raiseIn,
  input  wire logic              lowerIn,
  input  wire logic              driveRunning,
  input  wire logic              stopResetCfg,
  input  wire logic              terminalStripOrigin,
  input  wire logic              manualRefIsPot,
  input  wire logic [SPD_W-1:0]  topSpeed,
  input  wire logic [SPD_W-1:0]  minSpeed,
  input  wire logic [SPD_W-1:0]  maxSpeed,
  input  wire logic [TIME_W-1:0] riseTimeDs,
  input  wire logic [TIME_W-1:0] fallTimeDs,
  input  wire logic [TIME_W-1:0] driveAccelDs,
  input  wire logic [TIME_W-1:0] driveDecelDs,
  input  wire logic [SPD_W-1:0]  keypadRefIn,
  output logic      [SPD_W-1:0]  heldSpeedReference,
  output logic      [SPD_W-1:0]  speedLoopRef,
  output logic                   speedLoopRefValid,
  output logic      [SPD_W-1:0]  keypadRef,
  output logic                   stopResetOption
);
  localparam int ACC_W = SPD_W + FRAC_W;

  // Effective time: clamp to upper bound, then to drive ramp time floor
  function automatic logic [TIME_W-1:0] effTime(input logic [TIME_W-1:0] t,
                                                input logic [TIME_W-1:0] floorT);
    logic [TIME_W-1:0] v;
    v = (t > TIME_MAX_DS) ? TIME_MAX_DS : t;
    if (v < floorT)
      v = floorT;
    if (v == '0)
      v = TIME_RST_DS;
    return v;
  endfunction

  function automatic logic [ACC_W-1:0] clampRef(input logic [ACC_W:0] v,
                                                input logic [SPD_W-1:0] lo,
                                                input logic [SPD_W-1:0] hi);
    logic [ACC_W:0] loX, hiX;
    loX = {1'b0, lo, {FRAC_W{1'b0}}};
    hiX = {1'b0, hi, {FRAC_W{1'b0}}};
    if (v > hiX)
      v = hiX;
    if (v < loX)
      v = loX;
    return v[ACC_W-1:0];
  endfunction

  // Pin synchronisers
  logic [1:0] raiseSync_q, lowerSync_q, runSync_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      raiseSync_q <= 2'b00;
      lowerSync_q <= 2'b00;
      runSync_q   <= 2'b00;
    end
    else
    begin
      raiseSync_q <= {raiseSync_q[0], raiseIn};
      lowerSync_q <= {lowerSync_q[0], lowerIn};
      runSync_q   <= {runSync_q[0], driveRunning};
    end
  end

  logic     raiseS, lowerS, runS;
  mrs_dir_e dir;
  assign raiseS = raiseSync_q[1];
  assign lowerS = lowerSync_q[1];
  assign runS   = runSync_q[1];

  always_comb
  begin
    if (raiseS && !lowerS)
      dir = MRS_RAISE;
    else if (lowerS && !raiseS)
      dir = MRS_LOWER;
    else
      dir = MRS_HOLD;
  end

  // Tick counter and step computation
  logic [31:0]      tickCnt_q, tickCnt_d;
  logic             tick_q, tick_d;
  logic             calcUp_q, calcUp_d;
  logic [ACC_W-1:0] upStep_q, upStep_d, dnStep_q, dnStep_d;
  logic             divStart;
  logic [ACC_W-1:0] divQuot;
  logic             divDone;
  logic [23:0]      divDen;
  logic [TIME_W-1:0] timeSel;

  // Ticks per programmed time; rise and fall alternate through one divider
  always_comb
  begin
    if (calcUp_q)
      timeSel = effTime(riseTimeDs, driveAccelDs);
    else
      timeSel = effTime(fallTimeDs, driveDecelDs);
    divDen = 24'(timeSel) * 24'(TICKS_PER_DS);
  end

  assign divStart = 1'b1;

  mrs_step_div #(
    .NUM_W (ACC_W),
    .DEN_W (24)
  ) uStepDiv (
    .clk   (clk),
    .rst   (rst),
    .start (divStart),
    .numer ({topSpeed, {FRAC_W{1'b0}}}),
    .denom (divDen),
    .quot  (divQuot),
    .done  (divDone)
  );

  always_comb
  begin
    tickCnt_d = tickCnt_q + 32'h0000_0001;
    tick_d    = 1'b0;
    if (tickCnt_q >= 32'(TICK_LEN - 1))
    begin
      tickCnt_d = 32'h0000_0000;
      tick_d    = 1'b1;
    end
    calcUp_d = calcUp_q;
    upStep_d = upStep_q;
    dnStep_d = dnStep_q;
    // Step values refresh continuously so tuning takes effect within about a hundred cycles
    if (divDone)
    begin
      calcUp_d = !calcUp_q;
      if (calcUp_q)
        upStep_d = divQuot;
      else
        dnStep_d = divQuot;
    end
  end

  // Reference accumulator
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [SPD_W-1:0] keypad_q, keypad_d;
  logic             runPrev_q, stopEvt;
  logic [ACC_W:0]   sum;
  logic [SPD_W-1:0] loopRef_q, loopRef_d;
  logic             loopValid_q, loopValid_d;
  logic             stopOpt_q;

  assign stopEvt = runPrev_q && !runS;

  always_comb
  begin
    sum       = {1'b0, acc_q};
    keypad_d  = keypadRefIn;
    if (tick_q && dir == MRS_RAISE)
      sum = {1'b0, acc_q} + {1'b0, upStep_q};
    else if (tick_q && dir == MRS_LOWER)
      sum = ({1'b0, acc_q} > {1'b0, dnStep_q}) ? {1'b0, acc_q} - {1'b0, dnStep_q} : '0;
    acc_d = clampRef(sum, minSpeed, maxSpeed);
    // With the option off a stop takes the ramp path, so the reference is kept
    if (stopEvt && stopOpt_q)
    begin
      acc_d    = {minSpeed, {FRAC_W{1'b0}}};
      keypad_d = minSpeed;
    end
    loopValid_d = terminalStripOrigin && manualRefIsPot;
    loopRef_d   = loopValid_d ? acc_d[ACC_W-1:FRAC_W] : '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_q   <= 32'h0000_0000;
      tick_q      <= 1'b0;
      calcUp_q    <= 1'b1;
      upStep_q    <= '0;
      dnStep_q    <= '0;
      acc_q       <= {REF_RST, {FRAC_W{1'b0}}};
      keypad_q    <= REF_RST;
      runPrev_q   <= 1'b0;
      loopRef_q   <= REF_RST;
      loopValid_q <= 1'b0;
      stopOpt_q   <= STOP_RST_RST;
    end
    else
    begin
      tickCnt_q   <= tickCnt_d;
      tick_q      <= tick_d;
      calcUp_q    <= calcUp_d;
      upStep_q    <= upStep_d;
      dnStep_q    <= dnStep_d;
      acc_q       <= acc_d;
      keypad_q    <= keypad_d;
      runPrev_q   <= runS;
      loopRef_q   <= loopRef_d;
      loopValid_q <= loopValid_d;
      stopOpt_q   <= stopResetCfg;
    end
  end

  assign heldSpeedReference = acc_q[ACC_W-1:FRAC_W];
  assign speedLoopRef       = loopRef_q;
  assign speedLoopRefValid  = loopValid_q;
  assign keypadRef          = keypad_q;
  assign stopResetOption    = stopOpt_q;
endmodule

// ---- mrs_panel_model.sv ----
// Push-button panel model for the raise and lower inputs
`timescale 1ns/10ps
module mrs_panel_model
  import mrs_pkg::*;
(
  input  wire logic clk,
  input  mrs_dir_e  dir,
  input  wire logic both,
  output logic      raiseIn = 1'b0,
  output logic      lowerIn = 1'b0
);
  // Levels move on the falling edge so the rising edge sees them settled
  always @(negedge clk)
  begin
    raiseIn <= both || dir == MRS_RAISE;
    lowerIn <= both || dir == MRS_LOWER;
  end
endmodule

// ---- mrs_pkg.sv ----
// Package with constants and types for the manual ramp speed reference
package mrs_pkg;
  localparam int          SPD_W          = 16;
  localparam int          TIME_W         = 12;
  localparam int          CLK_HZ         = 125000000;
  localparam int          TICK_US        = 1000;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000000 * TICK_US;
  localparam int          TICKS_PER_DS   = 100000 / TICK_US;
  localparam logic [11:0] TIME_MAX_DS    = 12'hBB8;
  localparam logic [11:0] TIME_RST_DS    = 12'h032;
  localparam logic [15:0] REF_RST        = 16'h0000;
  localparam logic        STOP_RST_RST   = 1'b0;
  localparam int          FRAC_W         = 16;

  typedef enum logic [1:0] {
    MRS_HOLD  = 2'b00,
    MRS_RAISE = 2'b01,
    MRS_LOWER = 2'b11
  } mrs_dir_e;
endpackage

// ---- mrs_ramp_assertions.sv ----
// Port checker for the manual ramp speed reference
`timescale 1ns/10ps
module mrs_ramp_chk
  import mrs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             raiseIn,
  input wire logic             lowerIn,
  input wire logic             stopResetCfg,
  input wire logic             terminalStripOrigin,
  input wire logic             manualRefIsPot,
  input wire logic [SPD_W-1:0] minSpeed,
  input wire logic [SPD_W-1:0] maxSpeed,
  input wire logic [SPD_W-1:0] heldSpeedReference,
  input wire logic [SPD_W-1:0] speedLoopRef,
  input wire logic             speedLoopRefValid,
  input wire logic             stopResetOption
);
  logic [31:0] gap_q;
  logic        inRange;
  assign inRange = heldSpeedReference >= minSpeed && heldSpeedReference <= maxSpeed;
  // Starts at one tick so the first move after reset is not flagged
  always_ff @(posedge clk or posedge rst)
    if (rst)
      gap_q <= 32'(TICK_LEN);
    else
      gap_q <= $changed(heldSpeedReference) ? 32'h0000_0001 : gap_q + 32'h0000_0001;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  tick_gap_a: assert property ($changed(heldSpeedReference) && !stopResetOption
    |-> gap_q >= TICK_LEN) else $error("two moves in one tick");
  clamp_high_a: assert property ($changed(heldSpeedReference) && minSpeed <= maxSpeed
    |-> heldSpeedReference <= maxSpeed) else $error("above max");
  clamp_low_a: assert property ($changed(heldSpeedReference)
    |-> heldSpeedReference >= minSpeed) else $error("below min");
  route_flag_a: assert property (!$past(rst)
    |-> speedLoopRefValid == ($past(terminalStripOrigin) && $past(manualRefIsPot)))
    else $error("route flag");
  route_zero_a: assert property (!speedLoopRefValid |-> speedLoopRef == 16'h0000)
    else $error("ref while unrouted");
  option_copy_a: assert property (!$past(rst) && $stable(stopResetCfg)
    |-> stopResetOption == stopResetCfg) else $error("option copy");
  both_hold_a: assert property (
    (raiseIn && lowerIn && !stopResetOption && $past(inRange))[*8]
    |-> $stable(heldSpeedReference)) else $error("moved with both");
  no_rise_a: assert property (
    (!raiseIn && !stopResetOption && $past(inRange))[*8]
    |-> heldSpeedReference <= $past(heldSpeedReference)) else $error("rose unpressed");
  raise_c: cover property (raiseIn [*8]);
  max_c: cover property (heldSpeedReference == maxSpeed);
  option_c: cover property (stopResetOption && heldSpeedReference == minSpeed);
endmodule

bind mrs_manual_ramp mrs_ramp_chk #(.TICK_LEN(TICK_LEN)) chk (.*);

// ---- mrs_step_div.sv ----
// Sequential divider computing per-tick slew step from top speed and ramp time
`timescale 1ns/10ps
module mrs_step_div
  import mrs_pkg::*;
#(
  parameter int NUM_W = SPD_W + FRAC_W,
  parameter int DEN_W = 24
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] numer,
  input  wire logic [DEN_W-1:0] denom,
  output logic      [NUM_W-1:0] quot,
  output logic                  done
);
  logic [NUM_W-1:0] quot_q, quot_d, num_q, num_d;
  logic [DEN_W:0]   rem_q, rem_d;
  logic [5:0]       cnt_q, cnt_d;
  logic             busy_q, busy_d, done_q, done_d;
  logic [DEN_W:0]   trial;

  // Restoring division, one quotient bit per clock
  always_comb
  begin
    quot_d = quot_q;
    num_d  = num_q;
    rem_d  = rem_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trial  = '0;
    if (start && !busy_q)
    begin
      num_d  = numer;
      rem_d  = '0;
      cnt_d  = 6'(NUM_W);
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      trial = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};
      num_d = {num_q[NUM_W-2:0], 1'b0};
      if (trial >= {1'b0, denom})
      begin
        rem_d = trial - {1'b0, denom};
        quot_d = {quot_q[NUM_W-2:0], 1'b1};
      end
      else
      begin
        rem_d = trial;
        quot_d = {quot_q[NUM_W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 6'h01;
      if (cnt_q == 6'h01)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      quot_q <= '0;
      num_q  <= '0;
      rem_q  <= '0;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      quot_q <= quot_d;
      num_q  <= num_d;
      rem_q  <= rem_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign quot = quot_q;
  assign done = done_q;
endmodule

// ---- tb.sv ----
// Self-checking bench for the manual ramp speed reference
`timescale 1ns/10ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0d got %0d", n, e, g); end end
module tb
  import mrs_pkg::*;
;
  logic              clk = 1'b0, rst = 1'b1, both = 1'b0;
  logic              driveRunning = 1'b1, stopResetCfg = 1'b0;
  logic              terminalStripOrigin = 1'b0, manualRefIsPot = 1'b0;
  logic              raiseIn, lowerIn, speedLoopRefValid, stopResetOption;
  mrs_dir_e          dir = MRS_HOLD;
  logic [SPD_W-1:0]  topSpeed = 16'h03E8, minSpeed = 16'h0064, maxSpeed = 16'h0258;
  logic [SPD_W-1:0]  keypadRefIn = 16'h02BC, hs, speedLoopRef, keypadRef, h;
  logic [TIME_W-1:0] riseTimeDs = 12'h001, fallTimeDs = 12'h001;
  logic [TIME_W-1:0] driveAccelDs = 12'h001, driveDecelDs = 12'h001;
  int                failures = 0;
  int                checksDone = 0;

  // Ten-cycle tick: top 1000 over 0.1 s gives 10 per tick, 5 with a 0.2 s floor
  mrs_manual_ramp #(.TICK_LEN(10)) dut (.*, .heldSpeedReference(hs));
  mrs_panel_model pm (.*);

  always #4 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic push(input mrs_dir_e d, input logic b, input int n);
    dir <= d;
    both <= b;
    cyc(n);
    dir <= MRS_HOLD;
    both <= 1'b0;
    cyc(30);
  endtask

  task automatic results;
    if (failures == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    cyc(4);
    `CHK("option", 1'b0, stopResetOption)
    cyc(1);
    rst = 1'b0;
    cyc(150);
    `CHK("min", 16'h0064, hs)
    terminalStripOrigin = 1'b1;
    cyc(3);
    `CHK("route", 1'b0, speedLoopRefValid)
    manualRefIsPot = 1'b1;
    cyc(3);
    `CHK("route", 1'b1, speedLoopRefValid)
    push(MRS_RAISE, 1'b0, 200);
    `CHK("rise", 1'b1, hs inside {[16'h0122:16'h0136]})
    `CHK("loop", hs, speedLoopRef)
    h = hs;
    push(MRS_HOLD, 1'b1, 100);
    `CHK("both", h, hs)
    push(MRS_RAISE, 1'b0, 600);
    `CHK("max", 16'h0258, hs)
    driveAccelDs = 12'h002;
    driveDecelDs = 12'h002;
    cyc(120);
    push(MRS_LOWER, 1'b0, 200);
    `CHK("fall", 1'b1, hs inside {[16'h01EE:16'h01FA]})
    push(MRS_RAISE, 1'b0, 100);
    `CHK("rise", 1'b1, hs inside {[16'h0220:16'h022C]})
    push(MRS_LOWER, 1'b0, 2000);
    `CHK("min", 16'h0064, hs)
    // A zero time falls back to the 5.0 s default: 0.2 per tick, 50 ticks
    riseTimeDs = 12'h000;
    driveAccelDs = 12'h000;
    cyc(120);
    push(MRS_RAISE, 1'b0, 500);
    `CHK("default", 1'b1, hs inside {[16'h006C:16'h006E]})
    push(MRS_RAISE, 1'b0, 100);
    h = hs;
    driveRunning = 1'b0;
    cyc(10);
    `CHK("keep", h, hs)
    driveRunning = 1'b1;
    stopResetCfg = 1'b1;
    keypadRefIn = 16'h01F4;
    cyc(10);
    `CHK("option", 1'b1, stopResetOption)
    `CHK("pad", 16'h01F4, keypadRef)
    driveRunning = 1'b0;
    // Keypad reset stands for the one cycle after the synced stop edge
    cyc(3);
    `CHK("pad", 16'h0064, keypadRef)
    `CHK("stop", 16'h0064, hs)
    cyc(7);
    `CHK("stop", 16'h0064, hs)
    results;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results;
  end
endmodule
